// File: src/ocd_distributor.sv
// Dot routing of character, rim and background to RGB and aux channels
`timescale 1ns/1ps
`default_nettype none
module ocd_distributor #(
    parameter logic [1:0] FORMAT   = ocd_pkg::FMT_B,
    parameter logic       OUT_MODE = ocd_pkg::MODE_AUX
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // AXI4-Lite slave
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Dot stream from the character generator
    input  wire logic [3:0]  dot_row,
    input  wire logic [4:0]  dot_col,
    input  wire logic [2:0]  dot_rgb,
    input  wire logic        dot_rim,
    input  wire logic        dot_bg,
    input  wire logic        cell_aux_two,
    input  wire logic        cell_disp_off,
    input  wire logic        nb_rim_spill,
    input  wire logic        nb_bg_spill,
    input  wire logic        nb_aux_two,
    // Channel outputs
    output logic [2:0]       rgb_out,
    output logic             rgb_blanking,
    output logic             aux_one,
    output logic             aux_one_blanking,
    output logic             aux_two,
    output logic             aux_two_blanking
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic        aw_have_reg;
    logic [4:0]  aw_addr_reg;
    logic        w_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [15:0] row_cmd_reg;
    logic [2:0]  bg_ctrl_reg;
    logic        reject_reg;
    logic [23:0] table_flat;

    wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    wire rd_fire = s_axi_arvalid && !rvalid_reg;

    wire sel_cmd    = (aw_addr_reg == ocd_pkg::ADDR_ROW_CMD);
    wire sel_bg     = (aw_addr_reg == ocd_pkg::ADDR_BG_CTRL);
    wire sel_clr    = (aw_addr_reg == ocd_pkg::ADDR_CLEAR);
    wire sel_stat   = (aw_addr_reg == ocd_pkg::ADDR_STATUS);
    wire sel_rbits  = (aw_addr_reg == ocd_pkg::ADDR_ROW_BITS);
    wire wr_mapped  = sel_cmd || sel_bg || sel_clr || sel_stat || sel_rbits;

    // Output pin control word check
    wire [15:0] cmd_word  = w_data_reg[15:0];
    wire        cmd_full  = (w_strb_reg[1:0] == 2'h3);
    wire        cmd_valid = cmd_full
        && (cmd_word[ocd_pkg::CMD_OP_HI:ocd_pkg::CMD_OP_LO]
            == ocd_pkg::CMD_OPCODE)
        && (cmd_word[ocd_pkg::CMD_ZERO_HI:ocd_pkg::CMD_ZERO_LO] == 2'h0)
        && (cmd_word[ocd_pkg::CMD_ROW_HI:ocd_pkg::CMD_ROW_LO]
            < ocd_pkg::ROW_LIMIT);
    wire cmd_write  = wr_fire && sel_cmd;
    wire cmd_accept = cmd_write && cmd_valid;
    wire cmd_bad    = cmd_write && !cmd_valid;
    wire clr_pulse  = wr_fire && sel_clr && w_strb_reg[0] && w_data_reg[0];
    wire stat_w1c   = wr_fire && sel_stat && w_strb_reg[0] && w_data_reg[0];
    wire reject_next = cmd_bad || (reject_reg && !stat_w1c);

    wire [1:0] wr_resp = wr_mapped ? ocd_pkg::RESP_OKAY
                                   : ocd_pkg::RESP_SLVERR;

    wire [31:0] rd_mux =
        (s_axi_araddr == ocd_pkg::ADDR_ROW_CMD)  ? {16'h0000, row_cmd_reg} :
        (s_axi_araddr == ocd_pkg::ADDR_BG_CTRL)  ? {29'h0, bg_ctrl_reg} :
        (s_axi_araddr == ocd_pkg::ADDR_CLEAR)    ? 32'h0000_0000 :
        (s_axi_araddr == ocd_pkg::ADDR_STATUS)   ? {31'h0, reject_reg} :
        (s_axi_araddr == ocd_pkg::ADDR_ROW_BITS) ? {8'h00, table_flat} :
                                                   32'h0000_0000;
    wire rd_mapped = (s_axi_araddr == ocd_pkg::ADDR_ROW_CMD)
                  || (s_axi_araddr == ocd_pkg::ADDR_BG_CTRL)
                  || (s_axi_araddr == ocd_pkg::ADDR_CLEAR)
                  || (s_axi_araddr == ocd_pkg::ADDR_STATUS)
                  || (s_axi_araddr == ocd_pkg::ADDR_ROW_BITS);

    assign s_axi_awready = !aw_have_reg;
    assign s_axi_wready  = !w_have_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_have_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_reg) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && !w_have_reg) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_reg  <= 1'b0;
            bresp_reg   <= ocd_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= ocd_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_resp;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_mapped ? ocd_pkg::RESP_OKAY
                                        : ocd_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            row_cmd_reg <= ocd_pkg::ROW_CMD_RST;
            bg_ctrl_reg <= ocd_pkg::BG_CTRL_RST;
            reject_reg  <= 1'b0;
        end else begin
            if (clr_pulse) begin
                row_cmd_reg <= ocd_pkg::ROW_CMD_RST;
            end else if (cmd_accept) begin
                row_cmd_reg <= cmd_word;
            end
            if (wr_fire && sel_bg && w_strb_reg[0]) begin
                bg_ctrl_reg <= w_data_reg[2:0];
            end
            reject_reg <= reject_next;
        end
    end

    // ------------------------------------------------------------
    // Row routing bits
    // ------------------------------------------------------------
    logic row_aux1;
    logic row_aux2;

    ocd_row_table #(
        .ROWS       (ocd_pkg::ROWS)
    ) u_rows (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .clear      (clr_pulse),
        .wr_en      (cmd_accept),
        .wr_row     (cmd_word[ocd_pkg::CMD_ROW_HI:ocd_pkg::CMD_ROW_LO]),
        .wr_aux1    (cmd_word[ocd_pkg::CMD_AUX1_BIT]),
        .wr_aux2    (cmd_word[ocd_pkg::CMD_AUX2_BIT]),
        .rd_row     (dot_row),
        .rd_aux1    (row_aux1),
        .rd_aux2    (row_aux2),
        .table_flat (table_flat)
    );

    // ------------------------------------------------------------
    // Channel gating by format, row bits and column half
    // ------------------------------------------------------------
    wire col_lo = (dot_col < ocd_pkg::COL_HALF);
    wire col_hi = !col_lo;
    wire [1:0] rbits = {row_aux2, row_aux1};

    wire c_aux1 = (rbits == 2'b00) ? 1'b1 :
                  (rbits == 2'b01) ? col_lo :
                  (rbits == 2'b10) ? col_hi : 1'b0;
    wire c_aux2 = (rbits == 2'b00) ? 1'b0 :
                  (rbits == 2'b10) ? col_lo :
                  (rbits == 2'b01) ? col_hi : 1'b1;

    wire gate_aux1 = (FORMAT == ocd_pkg::FMT_A) ? !row_aux1 :
                     (FORMAT == ocd_pkg::FMT_B) ? 1'b1 :
                                                  c_aux1;
    wire gate_aux2 = (FORMAT == ocd_pkg::FMT_C) ? c_aux2 :
                                                  row_aux1;

    // Background enables: one shared bit unless in aux output mode
    wire aux_mode = (OUT_MODE == ocd_pkg::MODE_AUX);
    wire bg_rgb   = bg_ctrl_reg[0];
    wire bg_aux1  = aux_mode ? bg_ctrl_reg[1] : bg_ctrl_reg[0];
    wire bg_aux2  = aux_mode ? bg_ctrl_reg[2] : bg_ctrl_reg[0];

    // ------------------------------------------------------------
    // Per-channel dot composition
    // ------------------------------------------------------------
    wire shown_main = !cell_aux_two && !cell_disp_off;
    wire char_main  = shown_main && (|dot_rgb);
    wire hole_main  = cell_aux_two || cell_disp_off;
    wire rim_main   = hole_main && nb_rim_spill;
    wire bgsp_main  = cell_disp_off && !cell_aux_two
                      && nb_bg_spill;
    wire own_main   = shown_main && (dot_rim || (|dot_rgb));

    wire blk_rgb  = own_main || rim_main
                  || (bg_rgb && ((shown_main && dot_bg) || bgsp_main));
    wire blk_aux1 = own_main || rim_main
                  || (bg_aux1 && ((shown_main && dot_bg) || bgsp_main));

    wire char_a2  = cell_aux_two && (|dot_rgb);
    wire own_a2   = cell_aux_two && (dot_rim || (|dot_rgb));
    wire rim_a2   = nb_aux_two && nb_rim_spill
                  && (cell_aux_two || cell_disp_off);
    wire blk_aux2 = own_a2 || rim_a2
                  || (bg_aux2 && cell_aux_two && dot_bg);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rgb_out          <= 3'h0;
            rgb_blanking     <= 1'b0;
            aux_one          <= 1'b0;
            aux_one_blanking <= 1'b0;
            aux_two          <= 1'b0;
            aux_two_blanking <= 1'b0;
        end else begin
            rgb_out          <= shown_main ? dot_rgb : 3'h0;
            rgb_blanking     <= blk_rgb;
            aux_one          <= gate_aux1 && char_main;
            aux_one_blanking <= gate_aux1 && blk_aux1;
            aux_two          <= gate_aux2 && char_a2;
            aux_two_blanking <= gate_aux2 && blk_aux2;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_clear_write;
        wr_fire && sel_clr && w_strb_reg[0] && w_data_reg[0];
    endsequence
    sequence s_rows_zero;
        (table_flat == 24'h00_0000) ##1 (table_flat == 24'h00_0000);
    endsequence

    a_flag_main_off: assert property (
        $past(cell_aux_two) |-> (rgb_out == 3'h0) && !aux_one)
        else $error("flagged cell leaked onto rgb or aux one");
    a_fmta_aux1_low: assert property (
        (FORMAT == ocd_pkg::FMT_A) && $past(row_aux1)
        |-> !aux_one && !aux_one_blanking)
        else $error("format A aux one not low in aux one row");
    a_fmta_aux2_low: assert property (
        (FORMAT != ocd_pkg::FMT_C) && !$past(row_aux1)
        |-> !aux_two && !aux_two_blanking)
        else $error("aux two not low in aux one clear row");
    a_fmtb_aux1_all: assert property (
        (FORMAT == ocd_pkg::FMT_B) && $past(char_main) |-> aux_one)
        else $error("format B aux one dropped a character");
    a_fmtc_aux1_off: assert property (
        (FORMAT == ocd_pkg::FMT_C) && $past(row_aux1) && $past(row_aux2)
        |-> !aux_one && !aux_one_blanking)
        else $error("format C aux one not low");
    a_fmtc_aux2_hi: assert property (
        (FORMAT == ocd_pkg::FMT_C) && $past(rbits) == 2'b01
        && $past(col_lo) |-> !aux_two && !aux_two_blanking)
        else $error("format C aux two shown in low columns");
    a_bg_flag_none: assert property (
        $past(cell_aux_two) && !$past(nb_rim_spill) |-> !rgb_blanking)
        else $error("background painted over flagged cell");
    a_rim_into_flag: assert property (
        $past(cell_aux_two) && $past(nb_rim_spill)
        |-> rgb_blanking && (aux_one_blanking == $past(gate_aux1)))
        else $error("rim did not spill into flagged cell");
    a_aux2_no_bgspill: assert property (
        $past(cell_disp_off) && !$past(cell_aux_two)
        && !$past(nb_rim_spill) |-> !aux_two_blanking)
        else $error("background spilled on aux two");
    a_cmd_row_apply: assert property (
        cmd_accept |=> table_flat[2*$past(cmd_word[3:0])]
                       == $past(cmd_word[ocd_pkg::CMD_AUX1_BIT]))
        else $error("row command not applied");
    a_clear_rows: assert property (
        s_clear_write |=> s_rows_zero)
        else $error("batch clear left row bits set");
endmodule
`default_nettype wire

// File: src/ocd_pkg.sv
// Shared constants for the on-screen-display channel distributor
package ocd_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_ROW_CMD  = 5'h00;
    localparam logic [4:0] ADDR_BG_CTRL  = 5'h04;
    localparam logic [4:0] ADDR_CLEAR    = 5'h08;
    localparam logic [4:0] ADDR_STATUS   = 5'h0C;
    localparam logic [4:0] ADDR_ROW_BITS = 5'h10;
    // ------------------------------------------------------------
    // Field layout of the output pin control word
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OPCODE    = 8'h9C;
    localparam int         CMD_OP_HI     = 15;
    localparam int         CMD_OP_LO     = 8;
    localparam int         CMD_AUX2_BIT  = 7;
    localparam int         CMD_AUX1_BIT  = 6;
    localparam int         CMD_ZERO_HI   = 5;
    localparam int         CMD_ZERO_LO   = 4;
    localparam int         CMD_ROW_HI    = 3;
    localparam int         CMD_ROW_LO    = 0;
    // ------------------------------------------------------------
    // Geometry and reset values
    // ------------------------------------------------------------
    localparam int         ROWS          = 12;
    localparam int         COLS          = 24;
    localparam logic [4:0] COL_HALF      = 5'h0C;
    localparam logic [3:0] ROW_LIMIT     = 4'hC;
    localparam logic [2:0] BG_CTRL_RST   = 3'h7;
    localparam logic [15:0] ROW_CMD_RST  = 16'h0000;
    // ------------------------------------------------------------
    // Distribution formats and output modes
    // ------------------------------------------------------------
    localparam logic [1:0] FMT_A         = 2'h0;
    localparam logic [1:0] FMT_B         = 2'h1;
    localparam logic [1:0] FMT_C         = 2'h2;
    localparam logic       MODE_AUX      = 1'b1;
    localparam logic       MODE_3BLK     = 1'b0;
    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// File: src/ocd_row_table.sv
// Per-row aux channel routing bits with bulk clear
`timescale 1ns/1ps
`default_nettype none
module ocd_row_table #(
    parameter int ROWS = 12
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // Update side
    input  wire logic                clear,
    input  wire logic                wr_en,
    input  wire logic [3:0]          wr_row,
    input  wire logic                wr_aux1,
    input  wire logic                wr_aux2,
    // Lookup side
    input  wire logic [3:0]          rd_row,
    output logic                     rd_aux1,
    output logic                     rd_aux2,
    output logic [2*ROWS-1:0]        table_flat
);
    logic [ROWS-1:0] aux1_reg;
    logic [ROWS-1:0] aux2_reg;

    genvar r;
    generate
        for (r = 0; r < ROWS; r++) begin : g_row
            wire hit = wr_en && (wr_row == 4'(r));
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    aux1_reg[r] <= 1'b0;
                    aux2_reg[r] <= 1'b0;
                end else if (clear) begin
                    aux1_reg[r] <= 1'b0;
                    aux2_reg[r] <= 1'b0;
                end else if (hit) begin
                    aux1_reg[r] <= wr_aux1;
                    aux2_reg[r] <= wr_aux2;
                end
            end
            assign table_flat[2*r]   = aux1_reg[r];
            assign table_flat[2*r+1] = aux2_reg[r];
        end
    endgenerate

    // Out-of-range rows read as the default distribution
    wire row_ok = (rd_row < 4'(ROWS));
    assign rd_aux1 = row_ok ? aux1_reg[rd_row] : 1'b0;
    assign rd_aux2 = row_ok ? aux2_reg[rd_row] : 1'b0;
endmodule
`default_nettype wire

// File: bench/ocd_sink_model.sv
// Far-side capture of routed channel dots
`timescale 1ns/1ps
`default_nettype none
module ocd_sink_model (
    // Clock and stream
    input  wire logic       clk_sys,
    input  wire logic       in_valid,
    input  wire logic [7:0] dots_in,
    // Captured result
    output logic [7:0]      rx_word,
    output logic            rx_strobe
);
    logic v1;
    always_ff @(posedge clk_sys) begin
        v1        <= in_valid;
        rx_strobe <= v1;
        rx_word   <= dots_in;
    end
endmodule
`default_nettype wire

// File: bench/osd_channel_distributor_test.sv
// Self-checking bench for the channel distributor in all three formats
`timescale 1ns/1ps
`default_nettype none
module osd_channel_distributor_test;
    logic clk_sys, resetn, awv, wv, bry, arv, rry, dv;
    logic [4:0] awa, ara, col;
    logic [31:0] wd;
    logic [3:0] row;
    logic [2:0] rgb, bgc;
    logic [3:0] awr, wrd, bv, arr, rv, stb;
    logic rim, bg, fl, off, nr, nbg, na2;
    logic [1:0] br [4];
    logic [1:0] rr [4];
    logic [31:0] rd [4];
    logic [7:0] dq [4];
    logic [7:0] rx [4];
    logic [11:0] rb1, rb2;
    logic [31:0] ev;
    logic [31:0] exp_q [$];
    int bad_count, n_tests;
    // Fourth copy: format A in the shared-background output mode
    for (genvar f = 0; f < 4; f++) begin : g_fmt
        ocd_distributor #(.FORMAT(2'(f % 3)),
            .OUT_MODE(f < 3 ? ocd_pkg::MODE_AUX : ocd_pkg::MODE_3BLK)) dut_u (
            .clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awa),
            .s_axi_awvalid(awv), .s_axi_awready(awr[f]), .s_axi_wdata(wd),
            .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd[f]),
            .s_axi_bresp(br[f]), .s_axi_bvalid(bv[f]), .s_axi_bready(bry),
            .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr[f]),
            .s_axi_rdata(rd[f]), .s_axi_rresp(rr[f]), .s_axi_rvalid(rv[f]),
            .s_axi_rready(rry), .dot_row(row), .dot_col(col), .dot_rgb(rgb),
            .dot_rim(rim), .dot_bg(bg), .cell_aux_two(fl),
            .cell_disp_off(off), .nb_rim_spill(nr), .nb_bg_spill(nbg),
            .nb_aux_two(na2), .rgb_out(dq[f][7:5]), .rgb_blanking(dq[f][4]),
            .aux_one(dq[f][3]), .aux_one_blanking(dq[f][2]),
            .aux_two(dq[f][1]), .aux_two_blanking(dq[f][0]));
        ocd_sink_model sink_u (.clk_sys(clk_sys), .in_valid(dv),
            .dots_in(dq[f]), .rx_word(rx[f]), .rx_strobe(stb[f]));
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus_wr(logic [4:0] a, logic [31:0] d, logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge clk_sys);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            @(negedge clk_sys);
            ah = awv & awr[0]; wh = wv & wrd[0]; bh = bv[0]; r = br[0];
            @(posedge clk_sys);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (bh) begin
                bry <= 1'b0;
                check("bresp", 32'(er), 32'(r));
                return;
            end
        end
        bad_count++;
        final_report();
    endtask
    task automatic bus_rd(logic [4:0] a, logic [31:0] ed, logic [1:0] er);
        logic ah, rh;
        @(posedge clk_sys);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            @(negedge clk_sys);
            ah = arv & arr[0]; rh = rv[0];
            if (rh) check("rdata", ed, rd[0]);
            if (rh) check("rresp", 32'(er), 32'(rr[0]));
            @(posedge clk_sys);
            if (ah) arv <= 1'b0;
            if (rh) begin
                rry <= 1'b0;
                return;
            end
        end
        bad_count++;
        final_report();
    endtask
    function automatic logic [7:0] exp_dot(int fm, logic md);
        logic a1, a2, lo, g1, g2, ch, own, mn, bp, b1, b2;
        b1 = md ? bgc[1] : bgc[0];
        b2 = md ? bgc[2] : bgc[0];
        a1 = row < 4'hC ? rb1[row] : 1'b0;
        a2 = row < 4'hC ? rb2[row] : 1'b0;
        lo = col < ocd_pkg::COL_HALF;
        g1 = fm == 0 ? !a1 : fm == 1 ? 1'b1 :
             (!a2 & !a1) | (!a2 & a1 & lo) | (a2 & !a1 & !lo);
        g2 = fm < 2 ? a1 : (a2 & a1) | (a2 & !a1 & lo) | (!a2 & a1 & !lo);
        ch = |rgb;
        own = !fl & !off;
        mn = own & (rim | ch) | (fl | off) & nr;
        bp = own & bg | off & !fl & nbg;
        return {fl ? 3'h0 : rgb, mn | bgc[0] & bp, g1 & ch & own,
                g1 & (mn | b1 & bp), g2 & ch & fl,
                g2 & (fl & (rim | ch) | na2 & nr & (fl | off) | b2 & fl & bg)};
    endfunction
    task automatic dots(int n);
        logic [6:0] m;
        for (int k = 0; k < n; k++) begin
            @(posedge clk_sys);
            m = 7'($urandom);
            row <= 4'($urandom);
            col <= 5'($urandom_range(23));
            {rim, bg, fl, off, nr, nbg, na2} <= m;
            rgb <= m[3] ? 3'h0 : 3'($urandom);
            dv <= 1'b1;
            #1;
            exp_q.push_back({exp_dot(0, 1'b1), exp_dot(1, 1'b1),
                             exp_dot(2, 1'b1), exp_dot(0, 1'b0)});
        end
        @(posedge clk_sys);
        dv <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys)
        if (stb[0]) check("dots", exp_q.pop_front(), {rx[0], rx[1], rx[2], rx[3]});
    initial begin
        {resetn, awv, wv, bry, arv, rry, dv, awa, ara, wd} = '0;
        {row, col, rgb, rim, bg, fl, off, nr, nbg, na2} = '0;
        {rb1, rb2, bad_count, n_tests} = '0;
        bgc = ocd_pkg::BG_CTRL_RST;
        void'($urandom(32'h92CE));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        bus_rd(ocd_pkg::ADDR_BG_CTRL, 32'h7, ocd_pkg::RESP_OKAY);
        bus_rd(ocd_pkg::ADDR_ROW_BITS, 32'h0, ocd_pkg::RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 14; i++) begin
                logic [1:0] v;
                v = 2'($urandom);
                bus_wr(ocd_pkg::ADDR_ROW_CMD, {24'h9C, v, 2'h0, 4'(i)}, ocd_pkg::RESP_OKAY);
                if (i < 12) {rb2[i], rb1[i]} = v;
            end
            ev = '0;
            for (int i = 0; i < 12; i++) ev[2*i+:2] = {rb2[i], rb1[i]};
            bus_rd(ocd_pkg::ADDR_ROW_BITS, ev, ocd_pkg::RESP_OKAY);
            bgc = p == 0 ? 3'h7 : 3'($urandom);
            bus_wr(ocd_pkg::ADDR_BG_CTRL, 32'(bgc), ocd_pkg::RESP_OKAY);
            dots(300);
        end
        bus_wr(ocd_pkg::ADDR_CLEAR, 32'h1, ocd_pkg::RESP_OKAY);
        {rb1, rb2} = '0;
        bus_rd(ocd_pkg::ADDR_ROW_BITS, 32'h0, ocd_pkg::RESP_OKAY);
        dots(100);
        bus_rd(5'h14, 32'h0, ocd_pkg::RESP_SLVERR);
        bus_wr(5'h18, 32'h1, ocd_pkg::RESP_SLVERR);
        final_report();
    end
endmodule
`default_nettype wire
